// [common/hsmon_pkg.sv]
// Package with register map, field positions and reset values of the monitor register bank.
package hsmon_pkg;
    localparam logic [7:0] ADDR_ALERT_ENABLE = 8'h01;
    localparam logic [7:0] ADDR_LIVE_COND    = 8'h02;
    localparam logic [7:0] ADDR_FAULT_LOG    = 8'h03;
    localparam logic [7:0] ADDR_SENSE_RES    = 8'h04;
    localparam logic [7:0] ADDR_OUTV_RES     = 8'h05;
    localparam logic [7:0] ADDR_AUX_RES      = 8'h06;
    localparam int BIT_GPIO_OUT  = 6;
    localparam int BIT_FET_SHORT = 5;
    localparam int BIT_EN_CHANGE = 4;
    localparam int BIT_PWR_BAD   = 3;
    localparam int BIT_OVERCURR  = 2;
    localparam int BIT_UNDERV    = 1;
    localparam int BIT_OVERV     = 0;
    localparam int BIT_FET_ON    = 7;
    localparam int BIT_GPIO_IN   = 6;
    localparam logic [7:0] ALERT_ENABLE_RESET = 8'h00;
    localparam logic [7:0] ALERT_ENABLE_MASK  = 8'h7F;
    localparam logic [7:0] FAULT_MASK         = 8'h3F;
    localparam logic [7:0] ZERO_BYTE          = 8'h00;
    localparam logic [5:0] ZERO_FAULTS        = 6'h00;
endpackage : hsmon_pkg

// [common/hsmon_fault_if.sv]
// Interface carrying live fault conditions from the input stage to the register bank.
`timescale 1ns/100ps
interface hsmon_fault_if;
    logic [5:0] live;
    logic [5:0] event_set;
    modport src (output live, output event_set);
    modport dst (input live, input event_set);
endinterface : hsmon_fault_if

// [logic/hsmon_inputs.sv]
// Synchronises the monitored pins and derives live conditions and fault events.
`timescale 1ns/100ps
module hsmon_inputs (
    input  wire logic   clk,
    input  wire logic   rst_n,
    input  wire logic   fet_on,
    input  wire logic   sense_over_1mv,
    input  wire logic   card_present_n,
    input  wire logic   power_good_feedback,
    input  wire logic   overcurrent_cooldown,
    input  wire logic   overcurrent_fault,
    input  wire logic   undervoltage_input,
    input  wire logic   overvoltage_input,
    input  wire logic   gpio_pin_in,
    hsmon_fault_if.src  flt,
    output logic        fet_on_s,
    output logic        gpio_in_s
);
    logic [8:0] meta;
    logic [8:0] sync;
    logic [5:0] prev_live;
    logic       prev_en;
    logic [1:0] seed_pipe;
    logic       init_done;
    logic [5:0] live;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 9'h000;
            sync <= 9'h000;
        end else begin
            meta <= {gpio_pin_in, fet_on, sense_over_1mv, card_present_n,
                     power_good_feedback, overcurrent_cooldown, overcurrent_fault,
                     undervoltage_input, overvoltage_input};
            sync <= meta;
        end
    end

    assign fet_on_s  = sync[7];
    assign gpio_in_s = sync[8];

    always_comb begin
        live = 6'h00;
        live[hsmon_pkg::BIT_FET_SHORT] = sync[6] & ~sync[7];
        live[hsmon_pkg::BIT_EN_CHANGE] = ~sync[5];
        live[hsmon_pkg::BIT_PWR_BAD]   = ~sync[4];
        live[hsmon_pkg::BIT_OVERCURR]  = sync[3];
        live[hsmon_pkg::BIT_UNDERV]    = ~sync[1];
        live[hsmon_pkg::BIT_OVERV]     = sync[0];
    end
    assign flt.live = live;

    // Two cycles fill the synchroniser with real pin levels and one more seeds history.
    // Edge events stay off until then, so the reset value of the flops is never seen as an edge.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_live <= 6'h00;
            prev_en   <= 1'b0;
            seed_pipe <= 2'h0;
            init_done <= 1'b0;
        end else begin
            prev_live <= live;
            prev_en   <= sync[5];
            seed_pipe <= {seed_pipe[0], 1'h1};
            init_done <= seed_pipe[1];
        end
    end

    always_comb begin
        flt.event_set = 6'h00;
        if (init_done) begin
            flt.event_set[hsmon_pkg::BIT_FET_SHORT] = live[hsmon_pkg::BIT_FET_SHORT];
            flt.event_set[hsmon_pkg::BIT_EN_CHANGE] = sync[5] ^ prev_en;
            flt.event_set[hsmon_pkg::BIT_PWR_BAD]   = live[hsmon_pkg::BIT_PWR_BAD]
                                                    & ~prev_live[hsmon_pkg::BIT_PWR_BAD];
            flt.event_set[hsmon_pkg::BIT_OVERCURR]  = sync[2];
            flt.event_set[hsmon_pkg::BIT_UNDERV]    = live[hsmon_pkg::BIT_UNDERV]
                                                    & ~prev_live[hsmon_pkg::BIT_UNDERV];
            flt.event_set[hsmon_pkg::BIT_OVERV]     = live[hsmon_pkg::BIT_OVERV]
                                                    & ~prev_live[hsmon_pkg::BIT_OVERV];
        end
    end
endmodule : hsmon_inputs

// [logic/hsmon_regs.sv]
// Monitor and alert register bank of a hot-plug power controller.
`timescale 1ns/100ps
module hsmon_regs (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       ara_answered,
    input  wire logic       host_addressed,
    input  wire logic       gpio_is_output,
    input  wire logic       fet_on,
    input  wire logic       sense_over_1mv,
    input  wire logic       card_present_n,
    input  wire logic       power_good_feedback,
    input  wire logic       overcurrent_cooldown,
    input  wire logic       overcurrent_fault,
    input  wire logic       undervoltage_input,
    input  wire logic       overvoltage_input,
    input  wire logic       gpio_pin_in,
    output logic            gpio_pin_out,
    output logic            gpio_pin_oe,
    output logic            alert_out,
    output logic            alert_oe,
    input  wire logic       sense_done,
    input  wire logic [7:0] sense_data,
    input  wire logic       outv_done,
    input  wire logic [7:0] outv_data,
    input  wire logic       aux_done,
    input  wire logic [7:0] aux_data
);
    logic       rst_meta;
    logic       rst_n;
    logic [7:0] alert_enable;
    logic [5:0] fault_log;
    logic [7:0] sense_res;
    logic [7:0] outv_res;
    logic [7:0] aux_res;
    logic [5:0] alerted;
    logic       alert_active;
    logic       fet_on_s;
    logic       gpio_in_s;
    logic [7:0] live_condition;
    logic [7:0] next_rdata;
    logic [5:0] fault_clear;
    logic [5:0] new_fault;
    hsmon_fault_if flt ();

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction : hit

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    hsmon_inputs u_inputs (
        .clk                  (clk),
        .rst_n                (rst_n),
        .fet_on               (fet_on),
        .sense_over_1mv       (sense_over_1mv),
        .card_present_n       (card_present_n),
        .power_good_feedback  (power_good_feedback),
        .overcurrent_cooldown (overcurrent_cooldown),
        .overcurrent_fault    (overcurrent_fault),
        .undervoltage_input   (undervoltage_input),
        .overvoltage_input    (overvoltage_input),
        .gpio_pin_in          (gpio_pin_in),
        .flt                  (flt),
        .fet_on_s             (fet_on_s),
        .gpio_in_s            (gpio_in_s)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_enable <= hsmon_pkg::ALERT_ENABLE_RESET;
        end else if (reg_wr && hit(reg_addr, hsmon_pkg::ADDR_ALERT_ENABLE)) begin
            alert_enable <= reg_wdata & hsmon_pkg::ALERT_ENABLE_MASK;
        end
    end

    // Writing zero clears a bit; a hardware event in the same cycle still wins.
    always_comb begin
        fault_clear = 6'h00;
        if (reg_wr && hit(reg_addr, hsmon_pkg::ADDR_FAULT_LOG)) begin
            fault_clear = ~reg_wdata[5:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_log <= hsmon_pkg::ZERO_FAULTS;
        end else begin
            fault_log <= (fault_log & ~fault_clear) | flt.event_set;
        end
    end

    // Results are captured in one edge, so a read never sees a torn value.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sense_res <= hsmon_pkg::ZERO_BYTE;
            outv_res  <= hsmon_pkg::ZERO_BYTE;
            aux_res   <= hsmon_pkg::ZERO_BYTE;
        end else begin
            if (sense_done) begin
                sense_res <= sense_data;
            end else if (reg_wr && hit(reg_addr, hsmon_pkg::ADDR_SENSE_RES)) begin
                sense_res <= reg_wdata;
            end
            if (outv_done) begin
                outv_res <= outv_data;
            end else if (reg_wr && hit(reg_addr, hsmon_pkg::ADDR_OUTV_RES)) begin
                outv_res <= reg_wdata;
            end
            if (aux_done) begin
                aux_res <= aux_data;
            end else if (reg_wr && hit(reg_addr, hsmon_pkg::ADDR_AUX_RES)) begin
                aux_res <= reg_wdata;
            end
        end
    end

    // A fault alerts only on a newly set, enabled bit not already reported.
    assign new_fault = flt.event_set & ~fault_log & alert_enable[5:0];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alerted      <= hsmon_pkg::ZERO_FAULTS;
            alert_active <= 1'b0;
        end else begin
            alerted <= (alerted & fault_log & ~fault_clear) | new_fault;
            if (|(new_fault & ~alerted)) begin
                alert_active <= 1'b1;
            end else if (ara_answered || host_addressed) begin
                alert_active <= 1'b0;
            end
        end
    end

    always_comb begin
        live_condition = 8'h00;
        live_condition[5:0] = flt.live;
        live_condition[hsmon_pkg::BIT_FET_ON]  = fet_on_s;
        live_condition[hsmon_pkg::BIT_GPIO_IN] = gpio_in_s;
    end

    always_comb begin
        next_rdata = hsmon_pkg::ZERO_BYTE;
        if (hit(reg_addr, hsmon_pkg::ADDR_ALERT_ENABLE)) begin
            next_rdata = alert_enable;
        end else if (hit(reg_addr, hsmon_pkg::ADDR_LIVE_COND)) begin
            next_rdata = live_condition;
        end else if (hit(reg_addr, hsmon_pkg::ADDR_FAULT_LOG)) begin
            next_rdata = {2'b00, fault_log};
        end else if (hit(reg_addr, hsmon_pkg::ADDR_SENSE_RES)) begin
            next_rdata = sense_res;
        end else if (hit(reg_addr, hsmon_pkg::ADDR_OUTV_RES)) begin
            next_rdata = outv_res;
        end else if (hit(reg_addr, hsmon_pkg::ADDR_AUX_RES)) begin
            next_rdata = aux_res;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= hsmon_pkg::ZERO_BYTE;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // Open-drain alert: output held low, enable low while pulling the line down.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_out    <= 1'b0;
            alert_oe     <= 1'b1;
            gpio_pin_out <= 1'b0;
            gpio_pin_oe  <= 1'b1;
        end else begin
            alert_out    <= 1'b0;
            alert_oe     <= ~alert_active;
            gpio_pin_out <= alert_enable[hsmon_pkg::BIT_GPIO_OUT];
            gpio_pin_oe  <= ~gpio_is_output;
        end
    end
endmodule : hsmon_regs

// [dv/hsmon_regs_properties.sv]
// Concurrent checks on the ports of the monitor register bank.
`timescale 1ns/100ps
module hsmon_regs_props (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       ara_answered,
    input wire logic       host_addressed,
    input wire logic       gpio_is_output,
    input wire logic       gpio_pin_out,
    input wire logic       gpio_pin_oe,
    input wire logic       alert_out,
    input wire logic       alert_oe
);
    logic [7:0] en_shadow;
    // The enable byte is not a port, so a shadow copy lets the alert check see the mask.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            en_shadow <= 8'h00;
        end else if (reg_wr && reg_addr == hsmon_pkg::ADDR_ALERT_ENABLE) begin
            en_shadow <= reg_wdata & hsmon_pkg::ALERT_ENABLE_MASK;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_gpio_out_bit: assert property (
        (reg_wr && reg_addr == hsmon_pkg::ADDR_ALERT_ENABLE)
        |-> ##2 gpio_pin_out == $past(reg_wdata[6], 2)) else $error("gpio level wrong");
    a_gpio_oe_on: assert property (
        gpio_is_output [*2] |-> !gpio_pin_oe) else $error("gpio not driven");
    a_gpio_oe_off: assert property (
        (!gpio_is_output) [*2] |-> gpio_pin_oe) else $error("gpio driven as input");
    a_alert_open_drain: assert property (
        alert_out == 1'b0) else $error("alert driven high");
    a_alert_release: assert property (
        (ara_answered || host_addressed) |-> ##2 alert_oe) else $error("alert not released");
    a_alert_masked: assert property (
        $fell(alert_oe) |-> en_shadow[5:0] != 6'h00) else $error("alert while masked");
    a_rdata_holds: assert property (
        !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
    a_unmapped_zero: assert property (
        reg_rd && (reg_addr == 8'h00 || reg_addr > hsmon_pkg::ADDR_AUX_RES)
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_fault_reserved: assert property (
        reg_rd && reg_addr == hsmon_pkg::ADDR_FAULT_LOG |=> reg_rdata[7:6] == 2'h0)
        else $error("reserved fault bits set");
endmodule : hsmon_regs_props

bind hsmon_regs hsmon_regs_props u_props (
    .clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ara_answered(ara_answered),
    .host_addressed(host_addressed), .gpio_is_output(gpio_is_output),
    .gpio_pin_out(gpio_pin_out), .gpio_pin_oe(gpio_pin_oe), .alert_out(alert_out),
    .alert_oe(alert_oe));

// [dv/hsmon_host_model.sv]
// Host-side model issuing register reads, writes and alert release pulses.
`timescale 1ns/100ps
module hsmon_host_model (
    input  wire logic       clk,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    output logic            ara_answered,
    output logic            host_addressed
);
    initial begin
        {reg_wr, reg_rd, ara_answered, host_addressed} = 4'h0;
        {reg_addr, reg_wdata} = 16'h0000;
    end
    // Data is inverted once released so a stale byte can never pass as valid.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~v;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task automatic pulse(input logic ara);
        @(posedge clk);
        ara_answered   <= ara;
        host_addressed <= !ara;
        @(posedge clk);
        {ara_answered, host_addressed} <= 2'h0;
    endtask : pulse
endmodule : hsmon_host_model

// [dv/hsmon_regs_bench.sv]
// Self-checking bench for the monitor register bank.
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %0t mismatch got %h exp %h", $time, (g), (e)); end end
module hsmon_regs_bench;
    logic       clk, rstn, reg_wr, reg_rd, ara_answered, host_addressed, gpio_is_output;
    logic       fet_on, sense_over_1mv, card_present_n, power_good_feedback, gpio_ext;
    logic       overcurrent_cooldown, overcurrent_fault, undervoltage_input;
    logic       overvoltage_input, gpio_pin_in, gpio_pin_out, gpio_pin_oe, alert_out, alert_oe;
    logic       sense_done, outv_done, aux_done;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, sense_data, outv_data, aux_data, d;
    int         errors, n_checks;
    logic [15:0] rows [10] = '{16'h1A00, 16'h9A80, 16'h5A40, 16'h3A20, 16'hBA80,
                               16'h0A10, 16'h1208, 16'h1E04, 16'h1802, 16'h1B01};
    logic [7:0]  trig [6]  = '{8'h1B, 8'h18, 8'h1A, 8'h12, 8'h0A, 8'h3A};
    logic [7:0]  zs [4]    = '{8'h00, 8'h01, 8'h03, 8'h07};
    // The pin reads back what the block drives when its enable is low.
    assign gpio_pin_in = gpio_pin_oe ? gpio_ext : gpio_pin_out;
    hsmon_regs u_dut (.clk, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .ara_answered, .host_addressed, .gpio_is_output, .fet_on, .sense_over_1mv,
        .card_present_n, .power_good_feedback, .overcurrent_cooldown, .overcurrent_fault,
        .undervoltage_input, .overvoltage_input, .gpio_pin_in, .gpio_pin_out, .gpio_pin_oe,
        .alert_out, .alert_oe, .sense_done, .sense_data, .outv_done, .outv_data, .aux_done,
        .aux_data);
    hsmon_host_model u_host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .ara_answered, .host_addressed);
    task automatic finish_test;
        if (errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    task automatic set_pins(input logic [7:0] v);
        @(posedge clk);
        {fet_on, gpio_ext, sense_over_1mv, card_present_n, power_good_feedback,
         overcurrent_cooldown, undervoltage_input, overvoltage_input} <= v;
        repeat (6) @(posedge clk);
    endtask : set_pins
    task automatic trigger(input int k);
        if (k == 2) begin
            @(posedge clk);
            overcurrent_fault <= 1'b1;
            repeat (3) @(posedge clk);
            overcurrent_fault <= 1'b0;
        end else begin
            set_pins(trig[k]);
        end
    endtask : trigger
    task automatic conv(input logic [2:0] w, input logic [7:0] v);
        @(posedge clk);
        {aux_done, outv_done, sense_done} <= w;
        {aux_data, outv_data, sense_data} <= {3{v}};
        @(posedge clk);
        {aux_done, outv_done, sense_done} <= 3'h0;
        {aux_data, outv_data, sense_data} <= {3{~v}};
    endtask : conv
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #(20000 * 50);
        errors++;
        finish_test();
    end
    initial begin
        errors = 0;
        n_checks = 0;
        {rstn, gpio_is_output, gpio_ext, overcurrent_fault} = 4'h0;
        {fet_on, sense_over_1mv, overcurrent_cooldown, overvoltage_input} = 4'h0;
        {card_present_n, power_good_feedback, undervoltage_input} = 3'h7;
        {sense_done, outv_done, aux_done} = 3'h0;
        {sense_data, outv_data, aux_data} = 24'h000000;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        #1 `CHK({gpio_pin_out, gpio_pin_oe, alert_oe, alert_out}, 4'h6)
        for (int i = 0; i < 4; i++) begin
            u_host.rd(zs[i], d);
            `CHK(d, 8'h00)
        end
        for (int i = 0; i < 10; i++) begin
            set_pins(rows[i][15:8]);
            u_host.rd(hsmon_pkg::ADDR_LIVE_COND, d);
            `CHK(d, rows[i][7:0])
        end
        u_host.rd(hsmon_pkg::ADDR_FAULT_LOG, d);
        `CHK(d, 8'h3B)
        u_host.wr(hsmon_pkg::ADDR_FAULT_LOG, 8'hFF);
        u_host.rd(hsmon_pkg::ADDR_FAULT_LOG, d);
        `CHK(d, 8'h3B)
        u_host.wr(hsmon_pkg::ADDR_FAULT_LOG, 8'h00);
        trigger(2);
        repeat (6) @(posedge clk);
        u_host.rd(hsmon_pkg::ADDR_FAULT_LOG, d);
        `CHK(d, 8'h04)
        for (int k = 0; k < 6; k++) begin
            set_pins(8'h1A);
            u_host.wr(hsmon_pkg::ADDR_FAULT_LOG, 8'h00);
            u_host.wr(hsmon_pkg::ADDR_ALERT_ENABLE, 8'h3F ^ (8'h01 << k));
            trigger(k);
            repeat (8) @(posedge clk);
            #1 `CHK(alert_oe, 1'b1)
            set_pins(8'h1A);
            u_host.wr(hsmon_pkg::ADDR_FAULT_LOG, 8'h00);
            u_host.wr(hsmon_pkg::ADDR_ALERT_ENABLE, 8'h01 << k);
            trigger(k);
            for (int n = 0; n < 10 && alert_oe !== 1'b0; n++) begin
                @(posedge clk);
                #1;
            end
            `CHK(alert_oe, 1'b0)
            u_host.pulse(k[0]);
            @(posedge clk);
            #1 `CHK(alert_oe, 1'b1)
            repeat (8) @(posedge clk);
            #1 `CHK(alert_oe, 1'b1)
        end
        set_pins(8'h1A);
        u_host.wr(hsmon_pkg::ADDR_ALERT_ENABLE, 8'h40);
        gpio_is_output <= 1'b1;
        u_host.wr(hsmon_pkg::ADDR_LIVE_COND, 8'hFF);
        repeat (6) @(posedge clk);
        #1 `CHK({gpio_pin_oe, gpio_pin_out}, 2'h1)
        u_host.rd(hsmon_pkg::ADDR_LIVE_COND, d);
        `CHK(d, 8'h40)
        u_host.wr(hsmon_pkg::ADDR_ALERT_ENABLE, 8'hFF);
        u_host.rd(hsmon_pkg::ADDR_ALERT_ENABLE, d);
        `CHK(d, 8'h7F)
        conv(3'h1, 8'hA5);
        u_host.rd(hsmon_pkg::ADDR_SENSE_RES, d);
        `CHK(d, 8'hA5)
        conv(3'h4, 8'h3C);
        u_host.rd(hsmon_pkg::ADDR_AUX_RES, d);
        `CHK(d, 8'h3C)
        u_host.wr(hsmon_pkg::ADDR_SENSE_RES, 8'h11);
        u_host.rd(hsmon_pkg::ADDR_SENSE_RES, d);
        `CHK(d, 8'h11)
        fork
            u_host.wr(hsmon_pkg::ADDR_OUTV_RES, 8'h11);
            conv(3'h2, 8'h77);
        join
        u_host.rd(hsmon_pkg::ADDR_OUTV_RES, d);
        `CHK(d, 8'h77)
        gpio_is_output <= 1'b0;
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        u_host.rd(hsmon_pkg::ADDR_ALERT_ENABLE, d);
        `CHK(d, 8'h00)
        u_host.rd(hsmon_pkg::ADDR_FAULT_LOG, d);
        `CHK(d, 8'h00)
        finish_test();
    end
endmodule : hsmon_regs_bench
